// *** hw/sdr_dma_req.sv ***
// serial port dma request logic: rx/tx single and burst requests, data buffer,
// fixed role and slave first-bit capture for the control-word format
// assumes the serial clock and frame select pins are asynchronous to clk
// Contract
// - rx single while rx fifo not empty
// - rx burst at four or more
// - tx single while a tx slot empty
// - tx burst at four or fewer
// - single and burst requests independent
// - below watermark only single request
// - requests held until matching clear
// - reassert after clear if condition holds
// - requests low when disabled
// - handshake synchronous to bus clock
// - watermark half depth, four entries
// - slave samples first bit after select low
// - role fixed, no runtime switch
// - reset clears every register bit; the frame select synchroniser resets high and the buffer storage has no reset
// - register offsets fixed from base
// - two-bit dma control, offset 0x24
`timescale 1ns/100ps
module sdr_dma_req #(
   parameter int DEPTH = sdr_pkg::FIFO_DEPTH,
   parameter int WIDTH = sdr_pkg::DATA_W,
   parameter int BUF_DEPTH = sdr_pkg::BUF_DEPTH,
   parameter bit IS_MASTER = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // port control
   input wire logic port_enable,
   input wire logic ctrl_write,
   input wire logic [1:0] ctrl_wdata,
   output logic [1:0] dma_control_reg,
   input wire logic control_word_mode,
   // fifo levels from the port core
   input wire logic [sdr_pkg::LEVEL_W-1:0] rx_level,
   input wire logic [sdr_pkg::LEVEL_W-1:0] tx_level,
   // dma handshake
   output logic rx_single_request,
   output logic rx_burst_request,
   input wire logic rx_request_clear,
   output logic tx_single_request,
   output logic tx_burst_request,
   input wire logic tx_request_clear,
   // slave serial pins
   input wire logic serial_clock_in,
   input wire logic frame_select_in,
   input wire logic serial_data_in,
   // captured bit stream
   output logic rx_bit_valid,
   input wire logic rx_bit_ready,
   output logic [WIDTH-1:0] rx_bit_data,
   output logic first_bit_seen,
   output logic is_master
);
   logic [1:0] ctrl_ff;
   logic rx_en;
   logic tx_en;
   logic rx_single_cond;
   logic rx_burst_cond;
   logic tx_single_cond;
   logic tx_burst_cond;
   logic [sdr_pkg::LEVEL_W-1:0] tx_empty;
   logic [2:0] sclk_sync_ff;
   logic [1:0] fss_sync_ff;
   logic [1:0] sdi_sync_ff;
   logic sclk_rise;
   sdr_pkg::sdr_samp_t state_ff;
   logic [WIDTH-1:0] shift_ff;
   logic [$clog2(WIDTH+1)-1:0] bit_cnt_ff;
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic first_ff;

   // dma control register, two bits
   // dma control storage
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_ff <= sdr_pkg::DMA_CTRL_RESET;
      end
      else if (ctrl_write)
      begin
         ctrl_ff <= ctrl_wdata;
      end
   end
   assign dma_control_reg = ctrl_ff;

   assign rx_en = port_enable && ctrl_ff[sdr_pkg::DMA_CTRL_RX_BIT];
   assign tx_en = port_enable && ctrl_ff[sdr_pkg::DMA_CTRL_TX_BIT];

   // level conditions; the watermark is half of DEPTH
   // half depth watermark
   // tx_empty is the free room; the core never reports more than DEPTH
   assign tx_empty = sdr_pkg::LEVEL_W'(DEPTH) - tx_level;
   assign rx_single_cond = (rx_level != '0);
   assign rx_burst_cond = (rx_level >= sdr_pkg::LEVEL_W'(DEPTH / 2));
   assign tx_single_cond = (tx_empty != '0);
   assign tx_burst_cond = (tx_level <= sdr_pkg::LEVEL_W'(DEPTH / 2));

   // one generator per direction, both held until their own clear
   // independent requests
   sdr_req_dir u_rx (
      .clk(clk),
      .rstn(rstn),
      .enable(rx_en),
      .single_cond(rx_single_cond),
      .burst_cond(rx_burst_cond),
      .request_clear(rx_request_clear),
      .single_request(rx_single_request),
      .burst_request(rx_burst_request)
   );

   sdr_req_dir u_tx (
      .clk(clk),
      .rstn(rstn),
      .enable(tx_en),
      .single_cond(tx_single_cond),
      .burst_cond(tx_burst_cond),
      .request_clear(tx_request_clear),
      .single_request(tx_single_request),
      .burst_request(tx_burst_request)
   );

   // role is a build-time parameter, never a register
   // fixed role
   // a master build never enters the capture path, so its capture outputs stay quiet
   assign is_master = IS_MASTER;

   // serial clock synchroniser; stage 0 feeds only stage 1, stage 2 is for the edge
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sclk_sync_ff <= 3'h0;
      end
      else
      begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clock_in};
      end
   end

   // frame select synchroniser; resets to idle high so reset shows no false frame
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         fss_sync_ff <= 2'h3;
      end
      else
      begin
         fss_sync_ff <= {fss_sync_ff[0], frame_select_in};
      end
   end

   // data synchroniser; two stages, as deep as clock stage 1 that the edge uses, so bit and edge stay aligned
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sdi_sync_ff <= 2'h0;
      end
      else
      begin
         sdi_sync_ff <= {sdi_sync_ff[0], serial_data_in};
      end
   end
   // edge from stages 1 and 2, both past the first flop
   assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];

   // slave capture: the first bit is taken on the first rising edge
   // after select goes low; the select must meet two clk setup cycles
   // first bit sampling
   always_ff @(posedge clk)
   begin
      if (!rstn || IS_MASTER || !port_enable || !control_word_mode)
      begin
         state_ff <= sdr_pkg::SDR_IDLE;
      end
      else
      begin
         unique case (state_ff)
            sdr_pkg::SDR_IDLE:
            begin
               if (fss_sync_ff[1])
               begin
                  state_ff <= sdr_pkg::SDR_ARMED;
               end
            end
            sdr_pkg::SDR_ARMED:
            begin
               if (!fss_sync_ff[1])
               begin
                  state_ff <= sdr_pkg::SDR_FIRST;
               end
            end
            sdr_pkg::SDR_FIRST:
            begin
               if (fss_sync_ff[1])
               begin
                  state_ff <= sdr_pkg::SDR_ARMED;
               end
               else if (sclk_rise)
               begin
                  state_ff <= sdr_pkg::SDR_RUN;
               end
            end
            sdr_pkg::SDR_RUN:
            begin
               if (fss_sync_ff[1])
               begin
                  state_ff <= sdr_pkg::SDR_ARMED;
               end
            end
         endcase
      end
   end

   // shift register; a full word is offered to the buffer
   always_ff @(posedge clk)
   begin
      if (!rstn || state_ff == sdr_pkg::SDR_IDLE || state_ff == sdr_pkg::SDR_ARMED)
      begin
         shift_ff <= '0;
      end
      else if (push_valid && push_ready)
      begin
         shift_ff <= '0;
      end
      else if (sclk_rise && !fss_sync_ff[1] && !push_valid)
      begin
         shift_ff <= {shift_ff[WIDTH-2:0], sdi_sync_ff[1]};
      end
   end

   // bit counter; stops at a full word and waits there for buffer room
   always_ff @(posedge clk)
   begin
      if (!rstn || state_ff == sdr_pkg::SDR_IDLE || state_ff == sdr_pkg::SDR_ARMED)
      begin
         bit_cnt_ff <= '0;
      end
      else if (push_valid && push_ready)
      begin
         bit_cnt_ff <= '0;
      end
      else if (sclk_rise && !fss_sync_ff[1] && !push_valid)
      begin
         bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
   end
   // a bit edge while the word waits for room is dropped: back-pressure
   assign push_valid = (bit_cnt_ff == ($clog2(WIDTH+1))'(WIDTH));
   assign push_data = shift_ff;

   // first bit marker, one cycle pulse when the first edge is taken
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         first_ff <= 1'b0;
      end
      else
      begin
         first_ff <= (state_ff == sdr_pkg::SDR_FIRST) && sclk_rise && !fss_sync_ff[1];
      end
   end
   assign first_bit_seen = first_ff;

   // captured words queue here until the consumer takes them
   sdr_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(rx_bit_valid),
      .out_ready(rx_bit_ready),
      .out_data(rx_bit_data),
      .level()
   );
endmodule : sdr_dma_req

// *** hw/sdr_fifo.sv ***
// parameterised valid/ready fifo used in the receive data path
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module sdr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // occupancy
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [$clog2(DEPTH+1)-1:0] cnt_ff;
   logic push;
   logic pop;

   // honest full and empty from the count
   assign in_ready = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid = (cnt_ff != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_ff[rd_ptr_ff];
   assign level = cnt_ff;

   // storage has no reset; only pointers and count carry control state
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
      end
   end

   // occupancy counter
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt_ff <= '0;
      end
      else if (push && !pop)
      begin
         cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule : sdr_fifo

// *** hw/sdr_pkg.sv ***
// constants for the serial port dma request logic
// assumes a single bus clock domain; the dma control register is the only software register in this block
package sdr_pkg;
   // fifo geometry: eight entries, half-depth watermark
   localparam int FIFO_DEPTH = 8;
   localparam int LEVEL_W = 4;
   localparam logic [3:0] BURST_WATERMARK = 4'h4;
   // dma control field positions and reset value
   localparam logic [7:0] DMA_CTRL_OFFSET = 8'h24;
   localparam int DMA_CTRL_RX_BIT = 0;
   localparam int DMA_CTRL_TX_BIT = 1;
   localparam logic [1:0] DMA_CTRL_RESET = 2'h0;
   // data path buffer
   localparam int BUF_DEPTH = 4;
   localparam int DATA_W = 16;
   // frame select hold/setup figures in port core clock periods
   localparam int FSS_SETUP_CYCLES = 2;
   localparam int FSS_HOLD_CYCLES = 1;
   // slave sampling state
   typedef enum logic [1:0] {SDR_IDLE, SDR_ARMED, SDR_FIRST, SDR_RUN} sdr_samp_t;
endpackage : sdr_pkg

// *** hw/sdr_req_dir.sv ***
// request generator for one direction: single and burst, held until clear
// assumes level and clear are on the bus clock
`timescale 1ns/100ps
module sdr_req_dir (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // conditions
   input wire logic enable,
   input wire logic single_cond,
   input wire logic burst_cond,
   input wire logic request_clear,
   // requests
   output logic single_request,
   output logic burst_request
);
   logic single_ff;
   logic burst_ff;

   // set by level, held until clear; enable low forces both low
   always_ff @(posedge clk)
   begin
      if (!rstn || !enable)
      begin
         single_ff <= 1'b0;
         burst_ff <= 1'b0;
      end
      else if (request_clear)
      begin
         single_ff <= 1'b0;
         burst_ff <= 1'b0;
      end
      else
      begin
         single_ff <= single_ff | single_cond;
         burst_ff <= burst_ff | burst_cond;
      end
   end

   assign single_request = single_ff;
   assign burst_request = burst_ff;
endmodule : sdr_req_dir

// *** tb/sdr_dma_model.sv ***
// dma controller model for one direction: answers requests with a clear
// assumes the requests are registered on clk
`timescale 1ns/100ps
module sdr_dma_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bench control
   input wire logic auto_on,
   input wire logic kick,
   input wire logic [2:0] delay,
   // handshake
   input wire logic single_request,
   input wire logic burst_request,
   output logic request_clear
);
   logic [2:0] wait_ff;
   logic clr_ff;
   logic busy;
   assign busy = auto_on && (single_request || burst_request) && !clr_ff;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wait_ff <= 3'h0;
         clr_ff <= 1'b0;
      end
      else
      begin
         clr_ff <= busy && wait_ff == delay;
         wait_ff <= (busy && wait_ff != delay) ? wait_ff + 3'h1 : 3'h0;
      end
   end
   // a bench pulse lets scenarios clear at an exact edge
   assign request_clear = clr_ff | kick;
endmodule : sdr_dma_model

// *** tb/sdr_dma_req_chk.sv ***
// assertion checker for the dma request outputs of sdr_dma_req
// assumes one bus clock and a synchronous active-low reset
`timescale 1ns/100ps
module sdr_dma_req_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   input wire logic port_enable,
   input wire logic ctrl_write,
   input wire logic [1:0] ctrl_wdata,
   input wire logic [1:0] dma_control_reg,
   input wire logic is_master,
   input wire logic first_bit_seen,
   // levels
   input wire logic [sdr_pkg::LEVEL_W-1:0] rx_level,
   input wire logic [sdr_pkg::LEVEL_W-1:0] tx_level,
   // handshake
   input wire logic rx_single_request,
   input wire logic rx_burst_request,
   input wire logic rx_request_clear,
   input wire logic tx_single_request,
   input wire logic tx_burst_request,
   input wire logic tx_request_clear
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic rx_en;
   logic tx_en;
   // a direction runs only with port and its dma enable both on
   assign rx_en = port_enable & dma_control_reg[0];
   assign tx_en = port_enable & dma_control_reg[1];
   property p_rx_single;
      rx_en && rx_level != 4'h0 && !rx_request_clear |=> rx_single_request;
   endproperty
   a_rx_single: assert property (p_rx_single) else $error("rx single request missing");
   property p_rx_burst;
      rx_en && rx_level >= 4'h4 && !rx_request_clear |=> rx_burst_request;
   endproperty
   a_rx_burst: assert property (p_rx_burst) else $error("rx burst request missing");
   property p_rx_burst_low;
      rx_level < 4'h4 && !rx_burst_request |=> !rx_burst_request;
   endproperty
   a_rx_burst_low: assert property (p_rx_burst_low) else $error("rx burst below watermark");
   property p_tx_single;
      tx_en && tx_level < 4'h8 && !tx_request_clear |=> tx_single_request;
   endproperty
   a_tx_single: assert property (p_tx_single) else $error("tx single request missing");
   property p_tx_burst;
      tx_en && tx_level <= 4'h4 && !tx_request_clear |=> tx_burst_request;
   endproperty
   a_tx_burst: assert property (p_tx_burst) else $error("tx burst request missing");
   property p_hold;
      rx_single_request && rx_en && !rx_request_clear |=> rx_single_request;
   endproperty
   a_hold: assert property (p_hold) else $error("rx single dropped without clear");
   property p_rx_clear;
      rx_request_clear |=> !rx_single_request && !rx_burst_request;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx clear ignored");
   property p_tx_clear;
      tx_request_clear |=> !tx_single_request && !tx_burst_request;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("tx clear ignored");
   property p_off;
      !port_enable |=> !(rx_single_request | rx_burst_request | tx_single_request | tx_burst_request);
   endproperty
   a_off: assert property (p_off) else $error("request while port disabled");
   property p_ctrl;
      ctrl_write |=> dma_control_reg == $past(ctrl_wdata);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("dma control not loaded");
   property p_role;
      $stable(is_master) && !(is_master && first_bit_seen);
   endproperty
   a_role: assert property (p_role) else $error("role changed or master captured");
   property p_first;
      first_bit_seen |=> !first_bit_seen;
   endproperty
   a_first: assert property (p_first) else $error("first bit marker longer than one cycle");
endmodule : sdr_dma_req_chk

bind sdr_dma_req sdr_dma_req_chk i_chk (.clk, .rstn, .port_enable, .ctrl_write, .ctrl_wdata,
   .dma_control_reg, .is_master, .first_bit_seen, .rx_level, .tx_level, .rx_single_request, .rx_burst_request,
   .rx_request_clear, .tx_single_request, .tx_burst_request, .tx_request_clear);

// *** tb/serial_port_dma_request_logic_test.sv ***
// self-checking bench for sdr_dma_req with two dma controller models
// assumes the checker is bound in by its own file
`timescale 1ns/100ps
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module serial_port_dma_request_logic_test;
   logic clk = 1'b0, rstn = 1'b0, port_enable = 1'b0, ctrl_write = 1'b0, rx_bit_ready = 1'b0;
   logic kick = 1'b0, auto_on = 1'b0;
   logic [1:0] ctrl_wdata = 2'h0, dma_control_reg;
   logic [3:0] rx_level = 4'h0, tx_level = 4'h0;
   logic [2:0] delay = 3'h0;
   logic rx_s, rx_b, rx_c, tx_s, tx_b, tx_c;
   logic cw_mode = 1'b0, sclk = 1'b0, fsel = 1'b1, sdi = 1'b0, rx_valid, first_seen, role;
   logic [15:0] rx_data, w1 = 16'h0000;
   int n_errors = 0, comparisons = 0, seed = 81236, n_first = 0;
   sdr_dma_req #(.IS_MASTER(1'b0)) i_dut (.clk, .rstn, .port_enable, .ctrl_write, .ctrl_wdata, .dma_control_reg,
      .control_word_mode(cw_mode), .rx_level, .tx_level, .rx_single_request(rx_s), .rx_burst_request(rx_b),
      .rx_request_clear(rx_c), .tx_single_request(tx_s), .tx_burst_request(tx_b), .tx_request_clear(tx_c),
      .serial_clock_in(sclk), .frame_select_in(fsel), .serial_data_in(sdi), .rx_bit_valid(rx_valid),
      .rx_bit_ready, .rx_bit_data(rx_data), .first_bit_seen(first_seen), .is_master(role));
   sdr_dma_model i_rx (.clk, .rstn, .auto_on, .kick, .delay, .single_request(rx_s),
      .burst_request(rx_b), .request_clear(rx_c));
   sdr_dma_model i_tx (.clk, .rstn, .auto_on, .kick, .delay, .single_request(tx_s),
      .burst_request(tx_b), .request_clear(tx_c));
   // first bit markers, counted on the falling edge where the pulse is settled
   always @(negedge clk) n_first += int'(first_seen);
   // 100 ns clock
   initial
   begin
      forever #50 clk = ~clk;
   end
   // expected {rx single, rx burst, tx single, tx burst} for one level
   function automatic logic [3:0] exp_req(input int lvl);
      return {lvl >= 1, lvl >= 4, lvl < 8, lvl <= 4};
   endfunction : exp_req
   task test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task set_ctrl(input logic [1:0] v);
      @(posedge clk) ctrl_write <= 1'b1;
      ctrl_wdata <= v;
      @(posedge clk) ctrl_write <= 1'b0;
      @(negedge clk) `CHK(dma_control_reg, v, "dma control readback")
   endtask : set_ctrl
   // one clear pulse, then the requests are rebuilt from the levels
   task pulse_kick;
      @(posedge clk) kick <= 1'b1;
      @(posedge clk) kick <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : pulse_kick
   // one control-word frame into the slave, msb first, four clocks per serial half period;
   // select leads the first rising serial edge by four clocks, above the two-clock setup
   task send_word(input logic [15:0] w);
      @(posedge clk) fsel <= 1'b0;
      for (int b = 15; b >= 0; b--)
      begin
         sdi <= w[b];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      fsel <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : send_word
   // take one word from the capture buffer
   task take_word;
      @(posedge clk) rx_bit_ready <= 1'b1;
      @(posedge clk) rx_bit_ready <= 1'b0;
      @(negedge clk);
   endtask : take_word
   // watchdog sized well above the scripted run
   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      test_done;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      @(negedge clk) `CHK({rx_s, rx_b, tx_s, tx_b, dma_control_reg}, 6'h00, "reset values")
      @(posedge clk) rstn <= 1'b1;
      // every enable combination, port on and off
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) port_enable <= i[2];
         rx_level <= 4'h1;
         set_ctrl(i[1:0]);
         pulse_kick;
         `CHK({rx_s, tx_s}, {i[2] & i[0], i[2] & i[1]}, "enable gating")
      end
      // every level across both watermarks
      for (int l = 0; l <= 8; l++)
      begin
         @(posedge clk) rx_level <= l[3:0];
         tx_level <= l[3:0];
         pulse_kick;
         `CHK({rx_s, rx_b, tx_s, tx_b}, exp_req(l), "level thresholds")
      end
      // level drops to zero: requests held until the clear
      @(posedge clk) rx_level <= 4'h0;
      tx_level <= 4'h0;
      repeat (3) @(negedge clk);
      `CHK({rx_s, rx_b}, 2'h3, "requests held")
      pulse_kick;
      `CHK({rx_s, rx_b, tx_s, tx_b}, exp_req(0), "after clear")
      // slave capture in control-word mode: a random word, then a corner word, both queued
      @(posedge clk) cw_mode <= 1'b1;
      w1 <= 16'($random(seed));
      repeat (2) @(posedge clk);
      send_word(w1);
      send_word(16'h8001);
      @(negedge clk) `CHK(n_first, 2, "first bit markers")
      `CHK(role, 1'b0, "fixed slave role")
      `CHK({rx_valid, rx_data}, {1'b1, w1}, "first captured word")
      take_word;
      `CHK({rx_valid, rx_data}, {1'b1, 16'h8001}, "second captured word")
      take_word;
      `CHK(rx_valid, 1'b0, "capture buffer drained")
      // reset again in mid-run: control and requests return to zero
      @(posedge clk) rstn <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) `CHK({rx_s, rx_b, tx_s, tx_b, dma_control_reg, rx_valid}, 7'h00, "mid-run reset")
      @(posedge clk) rstn <= 1'b1;
      set_ctrl(2'h3);
      // random traffic against the answering models, prompt and slow
      @(posedge clk) auto_on <= 1'b1;
      for (int n = 0; n < 400; n++)
      begin
         @(posedge clk) rx_level <= 4'($unsigned($random(seed)) % 9);
         tx_level <= 4'($unsigned($random(seed)) % 9);
         delay <= 3'($random(seed));
         rx_bit_ready <= 1'($random(seed));
         port_enable <= ($random(seed) % 8) != 0;
      end
      test_done;
   end
endmodule : serial_port_dma_request_logic_test
